// >>> verilog/shc_standby_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "shc_consts.vh"
// Behaviour
// - STOP halts oscillator, both oscillator pins low
// - HALT stops CPU, oscillator and timer run
// - Standby keeps memory, accumulator, carry, ports
// - Standby entered only with status flag clear
// - Any standby release sets status flag
// - Flag set: clear unless release condition met
// - Release already true: skip entry, set flag
// - Reset restarts at zero, else next instruction
// - Codes 000/011 STOP, all key pins high
// - Code x110 STOP, first key pin high
// - STOP released by high on key input
// - Bit 3 adds enabled sense pins a, b
// - Sense pin c needs config bit 3
// - Code x101 HALT, released at timer zero
// - Bad operand or precondition forces system reset
// - STOP waits for timer and enable clear
// - Oscillation wait, back to STOP if gone
// - Timer decrements every 64 clocks, stops zero
module shc_standby_ctrl #(
  parameter [15:0] OSC_WAIT_CYCLES = `SHC_OSC_WAIT_CYCLES
) (
  input wire sys_clk_in, // System clock.
  input wire rst_n_in, // Power-on detector reset, active low.
  input wire halt_exec_in, // Halt instruction executes, one-cycle pulse.
  input wire [3:0] halt_operand_in, // Halt instruction operand.
  input wire status_flag_in, // Current status flag.
  input wire [7:0] key_drive_high_in, // Key pins driving high output.
  input wire [3:0] key_in_pins_in, // Key input pins.
  input wire sense_pin_a_in, // Sense pin a.
  input wire sense_pin_b_in, // Sense pin b.
  input wire sense_pin_c_in, // Sense pin c.
  input wire [7:0] pin_config_register_in, // Pin configuration register.
  input wire timer_load_in, // Timer load pulse.
  input wire [9:0] timer_value_in, // Timer load value.
  input wire timer_output_enable_in, // Timer output enable value.
  input wire timer_oe_load_in, // Timer output enable write.
  output reg cpu_run_out, // CPU may execute.
  output reg osc_enable_out, // System oscillator enable.
  output reg osc_input_pin_out, // Oscillator input pin drive.
  output reg osc_output_pin_out, // Oscillator output pin drive.
  output reg osc_pins_hold_out, // Oscillator pins forced low.
  output reg hold_state_out, // Retain memory, accumulator, carry, ports.
  output reg flag_set_out, // Set status flag, pulse.
  output reg flag_clear_out, // Clear status flag, pulse.
  output reg sys_reset_out, // Internal system reset, pulse.
  output reg pc_restart_out, // Restart at address zero, pulse.
  output reg pc_resume_out, // Continue after halt instruction, pulse.
  output reg [9:0] timer_count_out, // Timer down counter.
  output reg timer_output_enable_out, // Timer output enable flag.
  output reg timer_zero_out // Timer end of operation.
);
  // ****************************************************************
  // Reset release and pin synchronisation
  // ****************************************************************
  reg rst_s1_q;
  reg rst_q;
  always @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_s1_q <= 1'b0;
      rst_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_q <= rst_s1_q;
    end
  end
  wire [6:0] pins_s;
  shc_sync3 #(.W(7)) u_sync (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_q),
    .pin_in({sense_pin_c_in, sense_pin_b_in, sense_pin_a_in, key_in_pins_in}),
    .level_out(pins_s)
  );
  // ****************************************************************
  // Timer
  // ****************************************************************
  localparam ST_RUN = 5'h01;
  localparam ST_STOP_WAIT = 5'h02;
  localparam ST_STOP = 5'h04;
  localparam ST_OSC_WAIT = 5'h08;
  localparam ST_HALT = 5'h10;
  reg [4:0] state_q;
  reg [3:0] op_q;
  reg [`SHC_WAIT_W-1:0] wait_q;
  wire [9:0] t_count;
  wire t_oe;
  wire t_zero;
  shc_down_timer u_timer (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_q),
    .load_in(timer_load_in),
    .load_value_in(timer_value_in),
    .out_en_in(timer_output_enable_in),
    .out_en_load_in(timer_oe_load_in),
    .stop_clear_in(state_q == ST_STOP_WAIT),
    .count_out(t_count),
    .out_en_out(t_oe),
    .zero_out(t_zero)
  );
  // ****************************************************************
  // Operand decode
  // ****************************************************************
  function op_is_stop;
    input [3:0] op;
    begin
      op_is_stop = (op[2:0] == `SHC_OP_STOP_ALL_A) || (op[2:0] == `SHC_OP_STOP_ALL_B) ||
        (op[2:0] == `SHC_OP_STOP_KEY0);
    end
  endfunction
  function release_met;
    input [3:0] op;
    input [6:0] pins;
    input [7:0] cfg;
    input tz;
    reg sense;
    begin
      sense = (pins[4] & cfg[`SHC_CFG_SENSE_A_IN]) | (pins[5] & cfg[`SHC_CFG_SENSE_B_IN]) |
        (pins[6] & cfg[`SHC_CFG_SENSE_C_EN]);
      if (op[2:0] == `SHC_OP_HALT)
        release_met = tz;
      else
        release_met = (|pins[3:0]) | (op[`SHC_OP_SENSE_BIT] & sense);
    end
  endfunction
  wire op_stop = op_is_stop(halt_operand_in);
  wire op_halt = (halt_operand_in[2:0] == `SHC_OP_HALT);
  wire pre_ok = (halt_operand_in[2:0] == `SHC_OP_STOP_KEY0) ? key_drive_high_in[0] :
    op_halt ? 1'b1 : (&key_drive_high_in);
  wire rel_now = release_met(halt_operand_in, pins_s, pin_config_register_in, t_zero);
  wire rel_held = release_met(op_q, pins_s, pin_config_register_in, t_zero);
  // ****************************************************************
  // Standby sequencer
  // ****************************************************************
  always @(posedge sys_clk_in or negedge rst_q)
  begin
    if (!rst_q)
    begin
      state_q <= ST_RUN;
      op_q <= 4'h0;
      wait_q <= {`SHC_WAIT_W{1'b0}};
      cpu_run_out <= 1'b1;
      osc_enable_out <= 1'b1;
      osc_input_pin_out <= 1'b0;
      osc_output_pin_out <= 1'b0;
      osc_pins_hold_out <= 1'b0;
      hold_state_out <= 1'b0;
      flag_set_out <= 1'b0;
      flag_clear_out <= 1'b0;
      sys_reset_out <= 1'b0;
      pc_restart_out <= 1'b1;
      pc_resume_out <= 1'b0;
      timer_count_out <= 10'h000;
      timer_output_enable_out <= 1'b0;
      timer_zero_out <= 1'b1;
    end
    else
    begin
      flag_set_out <= 1'b0;
      flag_clear_out <= 1'b0;
      sys_reset_out <= 1'b0;
      pc_restart_out <= 1'b0;
      pc_resume_out <= 1'b0;
      timer_count_out <= t_count;
      timer_output_enable_out <= t_oe;
      timer_zero_out <= t_zero;
      case (state_q)
        ST_RUN:
        begin
          if (halt_exec_in)
          begin
            op_q <= halt_operand_in;
            if (!op_stop && !op_halt)
            begin
              sys_reset_out <= 1'b1;
              pc_restart_out <= 1'b1;
            end
            else if (status_flag_in)
            begin
              if (rel_now)
                flag_set_out <= 1'b1;
              else
                flag_clear_out <= 1'b1;
            end
            else if (!pre_ok)
            begin
              sys_reset_out <= 1'b1;
              pc_restart_out <= 1'b1;
            end
            else if (rel_now)
              flag_set_out <= 1'b1;
            else
            begin
              cpu_run_out <= 1'b0;
              hold_state_out <= 1'b1;
              state_q <= op_halt ? ST_HALT : ST_STOP_WAIT;
            end
          end
        end
        ST_STOP_WAIT:
        begin
          if (t_count == 10'h000 && !t_oe)
          begin
            osc_enable_out <= 1'b0;
            osc_pins_hold_out <= 1'b1;
            state_q <= ST_STOP;
          end
        end
        ST_STOP:
        begin
          if (rel_held)
          begin
            osc_enable_out <= 1'b1;
            osc_pins_hold_out <= 1'b0;
            wait_q <= OSC_WAIT_CYCLES;
            state_q <= ST_OSC_WAIT;
          end
        end
        ST_OSC_WAIT:
        begin
          if (wait_q > 16'h0001)
            wait_q <= wait_q - 16'h0001;
          else if (rel_held)
          begin
            cpu_run_out <= 1'b1;
            hold_state_out <= 1'b0;
            flag_set_out <= 1'b1;
            pc_resume_out <= 1'b1;
            state_q <= ST_RUN;
          end
          else
          begin
            osc_enable_out <= 1'b0;
            osc_pins_hold_out <= 1'b1;
            state_q <= ST_STOP;
          end
        end
        ST_HALT:
        begin
          if (t_zero)
          begin
            cpu_run_out <= 1'b1;
            hold_state_out <= 1'b0;
            flag_set_out <= 1'b1;
            pc_resume_out <= 1'b1;
            state_q <= ST_RUN;
          end
        end
        default:
          state_q <= ST_RUN;
      endcase
    end
  end
endmodule // shc_standby_ctrl
`default_nettype wire

// >>> verilog/shc_consts.vh
`ifndef SHC_CONSTS_VH
`define SHC_CONSTS_VH
// Operand low-bit codes.
`define SHC_OP_STOP_ALL_A 3'h0
`define SHC_OP_STOP_ALL_B 3'h3
`define SHC_OP_STOP_KEY0 3'h6
`define SHC_OP_HALT 3'h5
`define SHC_OP_SENSE_BIT 3
// Pin configuration fields.
`define SHC_CFG_SENSE_A_IN 0
`define SHC_CFG_SENSE_B_IN 2
`define SHC_CFG_SENSE_C_EN 3
`define SHC_CFG_RESET 8'h26
// Timer.
`define SHC_TIMER_PRESCALE 64
`define SHC_TICK_W 6
`define SHC_TIMER_W 10
// Oscillation wait after a STOP release condition, in system clocks.
`define SHC_OSC_WAIT_CYCLES 16'h0080
`define SHC_WAIT_W 16
`endif

// >>> verilog/shc_sync3.v
`timescale 1ns/1ps
`default_nettype none
// Three-stage pin synchroniser; a change counts once stages two and three agree.
module shc_sync3 #(
  parameter W = 1
) (
  input wire sys_clk_in, // System clock.
  input wire rst_n_in, // Active-low reset.
  input wire [W-1:0] pin_in, // Asynchronous pins.
  output reg [W-1:0] level_out // Filtered level.
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  always @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
      level_out <= {W{1'b0}};
    end
    else
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_out <= (s2_q & s3_q) | (~(s2_q ^ s3_q) ^ {W{1'b1}}) & level_out |
        (s2_q ^ s3_q) & level_out;
    end
  end
endmodule // shc_sync3
`default_nettype wire

// >>> verilog/shc_down_timer.v
`timescale 1ns/1ps
`default_nettype none
`include "shc_consts.vh"
// Ten-bit down counter, one step every prescale period; stops at zero.
module shc_down_timer (
  input wire sys_clk_in, // System clock.
  input wire rst_n_in, // Synchronised active-low reset.
  input wire load_in, // Load pulse.
  input wire [9:0] load_value_in, // Load value.
  input wire out_en_in, // Timer output enable value.
  input wire out_en_load_in, // Load the output enable.
  input wire stop_clear_in, // Clear enable flag at STOP entry.
  output reg [9:0] count_out, // Counter value.
  output reg out_en_out, // Timer output enable flag.
  output reg zero_out // Counter is zero.
);
  reg [`SHC_TICK_W-1:0] tick_q;
  always @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      tick_q <= {`SHC_TICK_W{1'b0}};
      count_out <= 10'h000;
      out_en_out <= 1'b0;
      zero_out <= 1'b1;
    end
    else
    begin
      if (load_in)
      begin
        count_out <= load_value_in;
        tick_q <= {`SHC_TICK_W{1'b0}};
        zero_out <= (load_value_in == 10'h000);
      end
      else if (count_out != 10'h000)
      begin
        tick_q <= tick_q + 6'h01;
        if (tick_q == 6'h3f)
        begin
          count_out <= count_out - 10'h001;
          zero_out <= (count_out == 10'h001);
        end
      end
      if (out_en_load_in)
        out_en_out <= out_en_in;
      else if (stop_clear_in && count_out == 10'h000)
        out_en_out <= 1'b0;
    end
  end
endmodule // shc_down_timer
`default_nettype wire

// >>> verification/shc_standby_props.sv
`timescale 1ns/1ps
`default_nettype none
module shc_standby_props #(
  parameter [15:0] OSC_WAIT_CYCLES = 16'h0004
) (
  input wire logic sys_clk_in, // Clock.
  input wire logic rst_n_in, // Reset.
  input wire logic halt_exec_in, // Halt.
  input wire logic [3:0] halt_operand_in, // Operand.
  input wire logic status_flag_in, // Flag.
  input wire logic [3:0] key_in_pins_in, // Keys.
  input wire logic cpu_run_out, // Run.
  input wire logic osc_enable_out, // Osc.
  input wire logic osc_input_pin_out, // Pin.
  input wire logic osc_output_pin_out, // Pin.
  input wire logic osc_pins_hold_out, // Hold.
  input wire logic hold_state_out, // Keep.
  input wire logic flag_set_out, // Set.
  input wire logic sys_reset_out, // Reset.
  input wire logic pc_restart_out, // Restart.
  input wire logic pc_resume_out, // Resume.
  input wire logic [9:0] timer_count_out, // Count.
  input wire logic timer_output_enable_out // Enable.
);
  logic [9:0] cnt_q;
  logic [7:0] gap_q;
  logic dec_q;
  // A load from zero to the top value is not a step; zero never steps down.
  wire dec_w = (cnt_q != 10'h000) && (timer_count_out == cnt_q - 10'h001);
  // Cycles between counter steps; only a step that follows a step is judged.
  always @(posedge sys_clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      cnt_q <= 10'h000;
      gap_q <= 8'h00;
      dec_q <= 1'b0;
    end
    else
    begin
      cnt_q <= timer_count_out;
      gap_q <= (timer_count_out != cnt_q) ? 8'h01 : gap_q + 8'h01;
      if (timer_count_out != cnt_q)
        dec_q <= dec_w;
    end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_exec;
    halt_exec_in && cpu_run_out;
  endsequence
  sequence s_halt_op;
    s_exec ##0 halt_operand_in[2:0] == 3'h5;
  endsequence
  a_bad_operand: assert property (s_exec ##0 halt_operand_in[2:0] inside {3'h1, 3'h2, 3'h4, 3'h7}
    |=> sys_reset_out && pc_restart_out) else $error("bad operand without reset");
  a_flag_blocks: assert property (s_halt_op ##0 status_flag_in |=> cpu_run_out)
    else $error("standby entered with flag set");
  a_halt_enter: assert property (s_halt_op ##0 !status_flag_in && timer_count_out != 10'h000
    |=> !cpu_run_out && osc_enable_out) else $error("halt mode not entered");
  a_release_flag: assert property ($rose(cpu_run_out) |-> flag_set_out && pc_resume_out)
    else $error("release without flag set and resume");
  a_osc_pins_low: assert property (!osc_enable_out |-> osc_pins_hold_out && !osc_input_pin_out
    && !osc_output_pin_out) else $error("oscillator pins not low in stop");
  a_standby_keeps: assert property (!cpu_run_out |-> hold_state_out)
    else $error("state not held in standby");
  a_stop_timer: assert property ($fell(osc_enable_out) |-> timer_count_out == 10'h000
    && !timer_output_enable_out) else $error("stop entered with timer active");
  a_key_wakes: assert property ((key_in_pins_in != 4'h0) [*8] |-> osc_enable_out)
    else $error("key high did not wake oscillator");
  a_osc_wait: assert property ($rose(osc_enable_out) |-> (osc_enable_out && !cpu_run_out) [*3])
    else $error("oscillation wait too short");
  a_timer_step: assert property (dec_w && dec_q |-> gap_q == 8'h40)
    else $error("timer step not 64 clocks");
endmodule // shc_standby_props
bind shc_standby_ctrl shc_standby_props #(.OSC_WAIT_CYCLES(OSC_WAIT_CYCLES)) props (.*);
`default_nettype wire

// >>> verification/shc_key_model.sv
`timescale 1ns/1ps
`default_nettype none
module shc_key_model (
  input wire logic [3:0] press_in, // Keys pressed.
  input wire logic [2:0] sense_in, // Sense pins driven high.
  input wire logic [7:0] drive_in, // Key drive pins high.
  output logic [3:0] key_out, // Key input pins.
  output logic [2:0] sense_out // Sense pins.
);
  // Every key joins the first drive pin; open inputs sit on pull-downs.
  assign key_out = press_in & {4{drive_in[0]}};
  assign sense_out = sense_in;
endmodule // shc_key_model
`default_nettype wire

// >>> verification/standby_halt_stop_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module standby_halt_stop_control_bench;
  logic clk, rst_n, exec, sflag, tld, oe, oeld;
  logic [3:0] op, press;
  logic [2:0] sen;
  logic [7:0] drv, cfg;
  logic [9:0] tval;
  wire [3:0] k_w;
  wire [2:0] s_w;
  wire [9:0] tcnt;
  wire run, osc, hold, fset, fclr, srst, rstrt, resm, toe, tz, ohold;
  int n_fail, cmp_count;
  logic [3:0] bad_ops [4] = '{4'h1, 4'ha, 4'h4, 4'hf};
  shc_key_model keys (.press_in(press), .sense_in(sen), .drive_in(drv), .key_out(k_w),
    .sense_out(s_w));
  shc_standby_ctrl #(.OSC_WAIT_CYCLES(16'h0004)) uut (.sys_clk_in(clk), .rst_n_in(rst_n),
    .halt_exec_in(exec), .halt_operand_in(op), .status_flag_in(sflag),
    .key_drive_high_in(drv), .key_in_pins_in(k_w), .sense_pin_a_in(s_w[0]),
    .sense_pin_b_in(s_w[1]), .sense_pin_c_in(s_w[2]), .pin_config_register_in(cfg),
    .timer_load_in(tld), .timer_value_in(tval), .timer_output_enable_in(oe),
    .timer_oe_load_in(oeld), .cpu_run_out(run), .osc_enable_out(osc),
    .osc_input_pin_out(), .osc_output_pin_out(), .osc_pins_hold_out(ohold),
    .hold_state_out(hold), .flag_set_out(fset), .flag_clear_out(fclr),
    .sys_reset_out(srst), .pc_restart_out(rstrt), .pc_resume_out(resm),
    .timer_count_out(tcnt), .timer_output_enable_out(toe), .timer_zero_out(tz));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(input logic [9:0] got, input logic [9:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task halt(input logic [3:0] o);
    op = o;
    exec = 1'b1;
    tick(1);
    exec = 1'b0;
  endtask
  task load(input logic [9:0] v);
    tval = v;
    tld = 1'b1;
    tick(1);
    tld = 1'b0;
    tick(3);
  endtask
  task wait_set(input int n);
    for (int i = 0; i < n && fset !== 1'b1; i++)
      tick(1);
  endtask
  task report_and_stop;
    $display("fails %0d compares %0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task t_bad_op;
    foreach (bad_ops[i])
    begin
      halt(bad_ops[i]);
      chk(srst, 1);
      chk(rstrt, 1);
      tick(8);
    end
  endtask
  task t_stop_key;
    drv = 8'hfe;
    halt(4'h0);
    chk(srst, 1);
    tick(8);
    drv = 8'h01;
    halt(4'h6);
    chk(srst, 0);
    tick(2);
    chk(osc, 0);
    chk(ohold, 1);
    press = 4'h2;
    tick(2);
    press = 4'h0;
    tick(20);
    chk(run, 0);
    press = 4'h4;
    wait_set(40);
    chk(fset, 1);
    chk(resm, 1);
    tick(1);
    press = 4'h0;
    drv = 8'hff;
    tick(8);
  endtask
  task t_sense(input logic [3:0] o, input logic [2:0] s, input logic [7:0] c0, c1);
    cfg = c0;
    halt(o);
    tick(2);
    sen = s;
    tick(20);
    chk(osc, 0);
    cfg = c1;
    wait_set(40);
    chk(fset, 1);
    sen = 3'h0;
    tick(8);
  endtask
  task t_halt;
    load(10'h003);
    halt(4'hd);
    chk(run, 0);
    chk(osc, 1);
    chk(hold, 1);
    wait_set(400);
    chk(fset, 1);
    chk(tz, 1);
  endtask
  task t_flag;
    load(10'h3ff);
    sflag = 1'b1;
    halt(4'h5);
    chk(fclr, 1);
    chk(run, 1);
    load(10'h000);
    halt(4'h5);
    chk(fclr, 0);
    chk(fset, 1);
    sflag = 1'b0;
    tick(2);
    halt(4'h5);
    chk(fset, 1);
    chk(run, 1);
  endtask
  task t_stop_timer;
    load(10'h002);
    oe = 1'b1;
    oeld = 1'b1;
    tick(1);
    oeld = 1'b0;
    halt(4'h0);
    chk(osc, 1);
    for (int i = 0; i < 400 && osc !== 1'b0; i++)
      tick(1);
    chk(osc, 0);
    chk(tcnt, 0);
    chk(toe, 0);
    press = 4'h1;
    wait_set(40);
    chk(fset, 1);
    press = 4'h0;
  endtask
  initial
  begin
    {rst_n, exec, sflag, tld, oe, oeld, op, press, sen, tval} = '0;
    drv = 8'hff;
    cfg = 8'h26;
    n_fail = 0;
    cmp_count = 0;
    tick(8);
    rst_n = 1'b1;
    tick(10);
    t_bad_op;
    t_stop_key;
    t_sense(4'h8, 3'h4, 8'h05, 8'h0d);
    t_sense(4'hb, 3'h1, 8'h04, 8'h05);
    t_halt;
    t_flag;
    t_stop_timer;
    report_and_stop;
  end
  initial
  begin
    #20000;
    n_fail++;
    report_and_stop;
  end
endmodule // standby_halt_stop_control_bench
`default_nettype wire
